// ===== common/pfs_params.svh
// Purpose: Constants of the program flow sequencer
// Assumes: Included by the sequencer design file and the bench
// Notes: Times are in their own units; cycle counts derive from them
// Notes on behaviour
// - Jump loads program counter with operand
// - Call pushes next address, then jumps
// - Return stack holds eight entries
// - Call with full stack does nothing
// - Return pops last saved address
// - Return with empty stack just advances
// - Wait holds program counter until done
// - Type selects one of five conditions
// - Tick wait stalls operand ticks
// - Event waits watch the selected motor
// - Event operand is timeout, zero none
// - Operand minus one takes accumulator
// - Expired timeout sets sticky error flag
// - Flag holds until clear-error instruction
// - Word is opcode, type, motor, value
// - Flow instructions act only in standalone
// - Conditional jump code eight tests flag
// - Accumulator shared, feeds wait value
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH
`define PFS_OP_JCOND 8'h15
`define PFS_OP_JUMP 8'h16
`define PFS_OP_CALL 8'h17
`define PFS_OP_RET 8'h18
`define PFS_OP_WAIT 8'h1B
`define PFS_OP_CLEAR_ERR 8'h24
`define PFS_JC_TIMEOUT 8'h08
`define PFS_WAIT_TICKS 8'h00
`define PFS_WAIT_TARGET 8'h01
`define PFS_WAIT_HOME_SWITCH 8'h02
`define PFS_WAIT_END_SWITCH 8'h03
`define PFS_WAIT_HOMING_DONE 8'h04
`define PFS_VAL_FROM_ACC 32'hFFFFFFFF
`define PFS_STACK_DEPTH 4'h8
`define PFS_PC_RESET 32'h00000000
`define PFS_MOTORS 8'h04
`define PFS_TICK_MS 10
`define PFS_CLK_KHZ 10000
`endif

// ===== common/pfs_pkg.sv
// Purpose: Types of the program flow sequencer
// Assumes: Single clock domain
// Notes: Constants live in pfs_params.svh
package pfs_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_LOAD  = 3'b010,
    S_EXEC  = 3'b011,
    S_WAIT  = 3'b100,
    S_POP   = 3'b101
  } seq_state_t;
endpackage

// ===== design/pfs_return_stack.sv
// Purpose: Eight-word return address memory
// Assumes: Stack pointer kept by the caller
// Notes: Read data is registered, so a pop takes one extra cycle
`timescale 1ns/1ns
module pfs_return_stack
(
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [31:0] rd_data_q
);
  logic [31:0] mem [0:7];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule

// ===== design/program_flow_sequencer.sv
// Purpose: Jump, call, return and wait part of the stored program engine
// Assumes: Program memory answers a fetch no earlier than one cycle later
// Notes: Opcodes outside the flow set are handed on with a strobe
`timescale 1ns/1ns
`include "pfs_params.svh"
module program_flow_sequencer
  import pfs_pkg::*;
#(
  parameter int TICK_CYCLES = `PFS_TICK_MS * `PFS_CLK_KHZ
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run_standalone,
  input wire logic instr_valid,
  input wire logic [7:0] instr_addr,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_type,
  input wire logic [7:0] instr_motor,
  input wire logic [7:0] instr_val3,
  input wire logic [7:0] instr_val2,
  input wire logic [7:0] instr_val1,
  input wire logic [7:0] instr_val0,
  input wire logic [7:0] instr_checksum,
  input wire logic [31:0] accumulator,
  input wire logic jc_cond_met,
  input wire logic [3:0] motor_at_target,
  input wire logic [3:0] motor_home_switch,
  input wire logic [3:0] motor_end_switch,
  input wire logic [3:0] motor_homing_done,
  output logic [31:0] pc_q,
  output logic fetch_q,
  output logic waiting_q,
  output logic timeout_error_flag_q,
  output logic checksum_err_q,
  output logic other_op_q,
  output logic [7:0] op_q,
  output logic [7:0] type_q,
  output logic [7:0] motor_q,
  output logic [31:0] val_q,
  output logic [3:0] sp_q,
  output logic tick_q
);
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  seq_state_t state_q, state_d;
  logic [16:0] tick_cnt_q;
  logic [31:0] count_q;
  logic to_en_q;
  logic csum_ok_q;
  logic [31:0] pc_d;
  logic [31:0] pop_data;

  // Event condition for the selected type; codes above four end at once
  function automatic logic cond_hit(input logic [7:0] t, input logic at,
    input logic hs, input logic es, input logic hd);
    case (t)
      `PFS_WAIT_TARGET: cond_hit = at;
      `PFS_WAIT_HOME_SWITCH: cond_hit = hs;
      `PFS_WAIT_END_SWITCH: cond_hit = es;
      `PFS_WAIT_HOMING_DONE: cond_hit = hd;
      default: cond_hit = 1'b1;
    endcase
  endfunction

  wire [7:0] sum_w = instr_addr + instr_opcode + instr_type + instr_motor
    + instr_val3 + instr_val2 + instr_val1 + instr_val0;
  wire take_w = (state_q == S_LOAD) && instr_valid;
  wire in_exec = (state_q == S_EXEC) && run_standalone;
  wire ex_ok = in_exec && csum_ok_q;
  wire ex_bad = in_exec && !csum_ok_q;
  wire ex_jump = ex_ok && (op_q == `PFS_OP_JUMP);
  wire ex_call = ex_ok && (op_q == `PFS_OP_CALL);
  wire ex_ret = ex_ok && (op_q == `PFS_OP_RET);
  wire ex_wait = ex_ok && (op_q == `PFS_OP_WAIT);
  wire ex_jc = ex_ok && (op_q == `PFS_OP_JCOND);
  wire ex_clr = ex_ok && (op_q == `PFS_OP_CLEAR_ERR);
  wire ex_other = ex_ok && !ex_jump && !ex_call && !ex_ret && !ex_wait
    && !ex_jc && !ex_clr;
  wire stack_full = (sp_q == `PFS_STACK_DEPTH);
  wire stack_empty = (sp_q == 4'h0);
  wire push_w = ex_call && !stack_full;
  wire pop_w = ex_ret && !stack_empty;
  wire jc_taken = (type_q == `PFS_JC_TIMEOUT) ? timeout_error_flag_q
    : jc_cond_met;
  wire [31:0] wait_load = (val_q == `PFS_VAL_FROM_ACC) ? accumulator
    : val_q;
  wire is_ticks = (type_q == `PFS_WAIT_TICKS);
  wire motor_ok = (motor_q < `PFS_MOTORS);
  wire [1:0] mi = motor_q[1:0];
  wire hit_w = motor_ok && cond_hit(type_q, motor_at_target[mi],
    motor_home_switch[mi], motor_end_switch[mi],
    motor_homing_done[mi]);
  wire in_wait = (state_q == S_WAIT) && run_standalone;
  wire last_tick = tick_q && (count_q == 32'h1);
  wire tick_done = is_ticks && (count_q == 32'h0);
  wire timeout_w = in_wait && !is_ticks && !hit_w && to_en_q
    && last_tick;
  wire wait_done = in_wait && (is_ticks ? tick_done
    : (hit_w || timeout_w));
  wire [31:0] pc_next = pc_q + 32'h1;

  pfs_return_stack u_stack
  (
    .sys_clk(sys_clk),
    .wr_en(push_w),
    .wr_addr(sp_q[2:0]),
    .wr_data(pc_next),
    .rd_addr(3'(sp_q - 4'h1)),
    .rd_data_q(pop_data)
  );

  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    case (state_q)
      S_IDLE:
      begin
        if (run_standalone)
        begin
          state_d = S_FETCH;
        end
      end
      S_FETCH:
      begin
        state_d = run_standalone ? S_LOAD : S_IDLE;
      end
      S_LOAD:
      begin
        if (!run_standalone)
        begin
          state_d = S_IDLE;
        end
        else if (instr_valid)
        begin
          state_d = S_EXEC;
        end
      end
      S_EXEC:
      begin
        state_d = S_FETCH;
        pc_d = pc_next;
        if (!run_standalone)
        begin
          state_d = S_IDLE;
          pc_d = pc_q;
        end
        else if (ex_jump || push_w || (ex_jc && jc_taken))
        begin
          pc_d = val_q;
        end
        else if (pop_w)
        begin
          state_d = S_POP;
          pc_d = pc_q;
        end
        else if (ex_wait)
        begin
          state_d = S_WAIT;
          pc_d = pc_q;
        end
      end
      S_WAIT:
      begin
        if (!run_standalone)
        begin
          state_d = S_IDLE;
        end
        else if (wait_done)
        begin
          state_d = S_FETCH;
          pc_d = pc_next;
        end
      end
      S_POP:
      begin
        state_d = S_FETCH;
        pc_d = pop_data;
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= S_IDLE;
      pc_q <= `PFS_PC_RESET;
      fetch_q <= 1'b0;
      waiting_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      fetch_q <= (state_d == S_FETCH);
      waiting_q <= (state_d == S_WAIT);
    end
  end

  // Fields are captured once so a slow memory may drop its outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      op_q <= 8'h00;
      type_q <= 8'h00;
      motor_q <= 8'h00;
      val_q <= 32'h00000000;
      csum_ok_q <= 1'b0;
    end
    else if (take_w)
    begin
      op_q <= instr_opcode;
      type_q <= instr_type;
      motor_q <= instr_motor;
      val_q <= {instr_val3, instr_val2, instr_val1, instr_val0};
      csum_ok_q <= (sum_w == instr_checksum);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sp_q <= 4'h0;
    end
    else if (push_w)
    begin
      sp_q <= sp_q + 4'h1;
    end
    else if (pop_w)
    begin
      sp_q <= sp_q - 4'h1;
    end
  end

  // Tick runs free, so the first tick of a wait may come after only part of a period
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || tick_cnt_q == TICK_LAST)
    begin
      tick_cnt_q <= 17'h00000;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_LAST);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      count_q <= 32'h00000000;
      to_en_q <= 1'b0;
    end
    else if (ex_wait)
    begin
      count_q <= wait_load;
      to_en_q <= (wait_load != 32'h00000000);
    end
    else if (in_wait && tick_q && count_q != 32'h00000000)
    begin
      count_q <= count_q - 32'h00000001;
    end
  end

  // A timeout in the same cycle as a clear still leaves the flag set
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      timeout_error_flag_q <= 1'b0;
      checksum_err_q <= 1'b0;
      other_op_q <= 1'b0;
    end
    else
    begin
      timeout_error_flag_q <= timeout_w
        || (timeout_error_flag_q && !ex_clr);
      checksum_err_q <= ex_bad;
      other_op_q <= ex_other;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_pop_start;
    ex_ret && !stack_empty;
  endsequence
  sequence seq_pop_end;
    state_q == S_POP ##1 state_q == S_FETCH;
  endsequence

  AST_JUMP: assert property (ex_jump |=> pc_q == $past(val_q))
    else $error("jump target not loaded");
  AST_CALL: assert property (ex_call && !stack_full |=>
    pc_q == $past(val_q) && sp_q == $past(sp_q) + 4'h1)
    else $error("call did not push and jump");
  AST_DEPTH: assert property (sp_q <= `PFS_STACK_DEPTH)
    else $error("stack pointer beyond depth");
  AST_CALL_FULL: assert property (ex_call && stack_full |=>
    sp_q == $past(sp_q) && pc_q == $past(pc_q) + 32'h1)
    else $error("call on full stack had an effect");
  AST_RET: assert property (seq_pop_start |=> seq_pop_end)
    else $error("return did not pop");
  AST_RET_EMPTY: assert property (ex_ret && stack_empty |=>
    pc_q == $past(pc_q) + 32'h1 && sp_q == 4'h0)
    else $error("return on empty stack not ignored");
  AST_HOLD: assert property (in_wait && !wait_done |=>
    pc_q == $past(pc_q))
    else $error("program counter moved during wait");
  AST_ACC: assert property (ex_wait && val_q == `PFS_VAL_FROM_ACC |=>
    count_q == $past(accumulator))
    else $error("accumulator not used as wait value");
  AST_TIMEOUT: assert property (timeout_w |=> timeout_error_flag_q
    && state_q == S_FETCH)
    else $error("timeout did not set flag");
  AST_STICKY: assert property (timeout_error_flag_q && !ex_clr |=>
    timeout_error_flag_q)
    else $error("timeout flag dropped without clear");
  AST_JC_ETO: assert property (ex_jc && type_q == `PFS_JC_TIMEOUT
    && timeout_error_flag_q |=> pc_q == $past(val_q))
    else $error("timeout branch not taken");
  AST_CSUM: assert property (ex_bad |=> checksum_err_q
    && pc_q == $past(pc_q) + 32'h1)
    else $error("bad checksum not reported");
  AST_TICK: assert property (tick_q |=> !tick_q)
    else $error("tick strobe longer than a cycle");
endmodule

// ===== dv/prog_mem_model.sv
// Purpose: Program memory answering each fetch with one frame
// Assumes: Bench fills mem; bit 56 marks a corrupt checksum
// Notes: Lines toggle when idle so stale bytes cannot pass
`timescale 1ns/1ns
module prog_mem_model
#(
  parameter logic [7:0] FRAME_ADDR = 8'h01
)
(
  input wire logic sys_clk,
  input wire logic fetch_q,
  input wire logic [31:0] pc_q,
  input wire logic [1:0] answer_delay,
  output logic instr_valid,
  output logic [7:0] instr_addr,
  output logic [7:0] instr_opcode,
  output logic [7:0] instr_type,
  output logic [7:0] instr_motor,
  output logic [7:0] instr_val3,
  output logic [7:0] instr_val2,
  output logic [7:0] instr_val1,
  output logic [7:0] instr_val0,
  output logic [7:0] instr_checksum
);
  logic [56:0] mem [256];
  logic [56:0] word;
  logic [7:0] sum;
  logic pend;
  logic [1:0] cnt;
  logic go;
  assign word = mem[pc_q[7:0]];
  assign sum = FRAME_ADDR + word[55:48] + word[47:40] + word[39:32]
    + word[31:24] + word[23:16] + word[15:8] + word[7:0]
    + {7'h0, word[56]};
  assign go = (fetch_q && answer_delay == 2'h0) || (pend && cnt == 2'h1);
  initial
  begin
    instr_valid = 1'b0;
    {instr_addr, instr_opcode, instr_type, instr_motor} = 32'h0;
    {instr_val3, instr_val2, instr_val1, instr_val0} = 32'h0;
    instr_checksum = 8'h00;
    pend = 1'b0;
    cnt = 2'h0;
  end
  always @(posedge sys_clk)
  begin
    instr_valid <= go;
    instr_checksum <= go ? sum : ~instr_checksum;
    // Value sent most significant byte first
    {instr_addr, instr_opcode, instr_type, instr_motor, instr_val3,
      instr_val2, instr_val1, instr_val0} <= go ? {FRAME_ADDR, word[55:0]}
      : ~{instr_addr, instr_opcode, instr_type, instr_motor, instr_val3,
      instr_val2, instr_val1, instr_val0};
    if (go)
      pend <= 1'b0;
    else if (fetch_q)
    begin
      pend <= 1'b1;
      cnt <= answer_delay;
    end
    else if (pend)
      cnt <= cnt - 2'h1;
  end
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench of the program flow sequencer
// Assumes: Short tick of 8 clocks; memory model answers fetches
// Notes: Program counter is tracked through each fetch
`timescale 1ns/1ns
`include "pfs_params.svh"
module tb_top;
  logic sys_clk, sys_rst, run_standalone, jc_cond_met;
  logic instr_valid, fetch_q, waiting_q, timeout_error_flag_q;
  logic checksum_err_q, other_op_q, tick_q;
  logic [7:0] i_ad, i_op, i_ty, i_mo, i_v3, i_v2, i_v1, i_v0, i_cs;
  logic [7:0] op_q, type_q, motor_q;
  logic [31:0] accumulator, pc_q, val_q;
  logic [3:0] sp_q;
  logic [15:0] ev;
  logic [1:0] answer_delay;
  int miscompares, cmp_count, seen_ticks, n_ticks, acc_ticks;
  bit seen_ce, seen_oo;
  logic [1:0] mot [4];
  program_flow_sequencer #(.TICK_CYCLES(8)) i_program_flow_sequencer (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .run_standalone(run_standalone),
    .instr_valid(instr_valid), .instr_addr(i_ad), .instr_opcode(i_op),
    .instr_type(i_ty), .instr_motor(i_mo), .instr_val3(i_v3),
    .instr_val2(i_v2), .instr_val1(i_v1), .instr_val0(i_v0),
    .instr_checksum(i_cs), .accumulator(accumulator),
    .jc_cond_met(jc_cond_met), .motor_at_target(ev[3:0]),
    .motor_home_switch(ev[7:4]), .motor_end_switch(ev[11:8]),
    .motor_homing_done(ev[15:12]), .pc_q(pc_q), .fetch_q(fetch_q),
    .waiting_q(waiting_q), .timeout_error_flag_q(timeout_error_flag_q),
    .checksum_err_q(checksum_err_q), .other_op_q(other_op_q),
    .op_q(op_q), .type_q(type_q), .motor_q(motor_q), .val_q(val_q),
    .sp_q(sp_q), .tick_q(tick_q));
  prog_mem_model i_prog_mem_model (
    .sys_clk(sys_clk), .fetch_q(fetch_q), .pc_q(pc_q),
    .answer_delay(answer_delay), .instr_valid(instr_valid),
    .instr_addr(i_ad), .instr_opcode(i_op), .instr_type(i_ty),
    .instr_motor(i_mo), .instr_val3(i_v3), .instr_val2(i_v2),
    .instr_val1(i_v1), .instr_val0(i_v0), .instr_checksum(i_cs));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  // Waits for the next fetch, noting ticks and pulses meanwhile
  task automatic fetch_is(input logic [31:0] exp);
    int i;
    seen_ticks = 0;
    seen_ce = 0;
    seen_oo = 0;
    for (i = 0; i < 500; i++)
    begin
      @(negedge sys_clk);
      if (tick_q === 1'b1 && waiting_q === 1'b1)
        seen_ticks++;
      if (checksum_err_q === 1'b1)
        seen_ce = 1;
      if (other_op_q === 1'b1)
        seen_oo = 1;
      if (fetch_q === 1'b1)
        break;
    end
    // A fetch that never comes shows up as a missing pulse
    chk_b(fetch_q, 1'b1);
    chk_w(pc_q, exp);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] op,
    input logic [7:0] ty, input logic [7:0] mo, input logic [31:0] v,
    input logic bad);
    i_prog_mem_model.mem[a] = {bad, op, ty, mo, v};
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end
  initial
  begin
    sys_rst = 1'b1;
    run_standalone = 1'b0;
    // Compare result held true: code eight must still ignore it
    jc_cond_met = 1'b1;
    ev = 16'h0;
    answer_delay = 2'h0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(35786));
    n_ticks = $urandom_range(4, 1);
    acc_ticks = $urandom_range(3, 1);
    accumulator = acc_ticks;
    for (int k = 0; k < 4; k++)
      mot[k] = 2'($urandom_range(3, 0));
    put(8'h00, `PFS_OP_RET, 8'h00, 8'h00, 32'h0, 1'b0);
    put(8'h01, `PFS_OP_JUMP, 8'($urandom), 8'($urandom), 32'h10, 1'b0);
    put(8'h10, `PFS_OP_CALL, 8'h00, 8'h00, 32'h20, 1'b0);
    put(8'h20, `PFS_OP_RET, 8'h00, 8'h00, 32'h0, 1'b0);
    put(8'h11, `PFS_OP_WAIT, `PFS_WAIT_TICKS, 8'($urandom), n_ticks, 1'b0);
    put(8'h12, `PFS_OP_WAIT, `PFS_WAIT_TARGET, {6'h0, mot[0]}, 32'h2,
      1'b0);
    put(8'h13, `PFS_OP_JCOND, `PFS_JC_TIMEOUT, 8'h00, 32'h30, 1'b0);
    put(8'h30, `PFS_OP_CLEAR_ERR, 8'h00, 8'h00, 32'h0, 1'b0);
    put(8'h31, `PFS_OP_WAIT, 8'h00, 8'h00, `PFS_VAL_FROM_ACC, 1'b0);
    for (int k = 0; k < 4; k++)
      put(8'(8'h32 + k), `PFS_OP_WAIT, 8'(k + 1), {6'h0, mot[k]}, 32'h0,
        1'b0);
    put(8'h36, `PFS_OP_JUMP, 8'h00, 8'h00, 32'h70, 1'b1);
    put(8'h37, 8'h13, 8'h02, 8'h00, 32'h0A0B0C0D, 1'b0);
    put(8'h38, `PFS_OP_CALL, 8'h00, 8'h00, 32'h40, 1'b0);
    for (int k = 0; k < 7; k++)
      put(8'(8'h40 + k), `PFS_OP_CALL, 8'h00, 8'h00, 32'h41 + k, 1'b0);
    put(8'h47, `PFS_OP_CALL, 8'h00, 8'h00, 32'h70, 1'b0);
    put(8'h48, `PFS_OP_RET, 8'h00, 8'h00, 32'h0, 1'b0);
    put(8'h70, `PFS_OP_JCOND, `PFS_JC_TIMEOUT, 8'h00, 32'h80, 1'b0);
    put(8'h71, `PFS_OP_JCOND, 8'h05, 8'h00, 32'h90, 1'b0);
    put(8'h90, `PFS_OP_JUMP, 8'h00, 8'h00, 32'h90, 1'b0);
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run_standalone <= 1'b1;
    fetch_is(32'h0);
    fetch_is(32'h1);
    fetch_is(32'h10);
    fetch_is(32'h20);
    fetch_is(32'h11);
    fetch_is(32'h12);
    chk_w(seen_ticks, n_ticks);
    fetch_is(32'h13);
    chk_w(seen_ticks, 32'h2);
    chk_b(timeout_error_flag_q, 1'b1);
    fetch_is(32'h30);
    chk_b(timeout_error_flag_q, 1'b1);
    fetch_is(32'h31);
    chk_b(timeout_error_flag_q, 1'b0);
    fetch_is(32'h32);
    chk_w(seen_ticks, acc_ticks);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      answer_delay <= 2'($urandom_range(3, 0));
      // Other motors true: only the selected one may end the wait
      ev <= {12'h0, ~(4'h1 << mot[k])} << (4 * k);
      repeat (40) @(negedge sys_clk);
      chk_b(waiting_q, 1'b1);
      @(posedge sys_clk);
      ev <= 16'h000F << (4 * k);
      fetch_is(32'h33 + k);
      chk_b(timeout_error_flag_q, 1'b0);
    end
    @(posedge sys_clk);
    ev <= 16'h0;
    fetch_is(32'h37);
    chk_b(seen_ce, 1'b1);
    fetch_is(32'h38);
    chk_b(seen_oo, 1'b1);
    chk_w({op_q, type_q, motor_q, 8'h00}, 32'h13020000);
    chk_w(val_q, 32'h0A0B0C0D);
    for (int k = 0; k < 8; k++)
      fetch_is(32'h40 + k);
    chk_w({28'h0, sp_q}, 32'h8);
    fetch_is(32'h48);
    chk_w({28'h0, sp_q}, 32'h8);
    fetch_is(32'h47);
    chk_w({28'h0, sp_q}, 32'h7);
    fetch_is(32'h70);
    chk_w({28'h0, sp_q}, 32'h8);
    fetch_is(32'h71);
    fetch_is(32'h90);
    @(posedge sys_clk);
    run_standalone <= 1'b0;
    repeat (3) @(negedge sys_clk);
    seen_ticks = 0;
    repeat (30)
    begin
      @(negedge sys_clk);
      if (fetch_q !== 1'b0)
        seen_ticks++;
    end
    chk_w(seen_ticks, 32'h0);
    conclude();
  end
endmodule
